// [bench/stat_host.sv]
// Host side model that gathers one page
`timescale 1ns/10ps
`default_nettype none
module stat_host (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic stall, // Accept every other cycle
  input wire logic clear, // Start a new page
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_valid,
  output logic out_ready
);
  logic [7:0] pg_buf [512]; // Page bytes
  int n = 0; // Bytes gathered
  logic done = 1'b0; // Final byte seen
  wire logic supported = {pg_buf[1], pg_buf[0]} != 16'h0000;
  initial out_ready = 1'b0;
  // Gather bytes, ready changes just after the edge
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      out_ready <= 1'b0;
    else
    begin
      if (clear)
      begin
        n <= 0;
        done <= 1'b0;
      end
      else if (out_valid && out_ready)
      begin
        pg_buf[n] <= out_data;
        n <= n + 1;
        done <= out_last;
      end
      out_ready <= #1 (stall ? !out_ready : 1'b1);
    end
  end
endmodule // stat_host
`default_nettype wire

// [bench/stat_pages_props.sv]
// Checker on the page byte stream of the statistics formatter
`timescale 1ns/10ps
`default_nettype none
module stat_pages_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic [7:0] req_page,
  input wire logic req_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_valid,
  input wire logic out_ready
);
  logic [8:0] cnt_reg; // Offset of byte on out_data
  logic [7:0] pg_reg; // Page now leaving
  logic [7:0] nx_reg; // Page last taken
  wire logic beat = out_valid && out_ready;
  wire logic take = req_valid && req_ready;
  wire logic [7:0] cur = (cnt_reg == 9'h000) ? nx_reg : pg_reg;
  wire logic impl = cur == 8'h00 || cur == 8'h01 || cur == 8'h03;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Follow offset and page of each byte
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg <= 9'h000;
      pg_reg <= 8'h00;
      nx_reg <= 8'h00;
    end
    else
    begin
      if (take) nx_reg <= req_page;
      if (beat && cnt_reg == 9'h000) pg_reg <= nx_reg;
      if (beat) cnt_reg <= out_last ? 9'h000 : cnt_reg + 9'h001;
    end
  end
  a_byte_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last)) else $error("byte lost in stall");
  a_last_end: assert property (beat |-> out_last == (cnt_reg == 9'h1FF))
    else $error("page end misplaced");
  a_answer_soon: assert property (take && !out_valid |-> ##[2:4] out_valid)
    else $error("page late");
  a_index_count: assert property (beat && cur == 8'h00 && cnt_reg == 9'h008 |-> out_data == 8'h03)
    else $error("bad count");
  a_index_list: assert property (beat && cur == 8'h00 && cnt_reg inside {[9'h009:9'h00B]}
    |-> out_data == (cnt_reg == 9'h009 ? 8'h00 : cnt_reg == 9'h00A ? 8'h01 : 8'h03)) else $error("bad list");
  a_header_page: assert property (beat && cnt_reg == 9'h002 |-> out_data == (impl ? cur : 8'h00))
    else $error("bad page number");
  a_rev_low: assert property (beat && cnt_reg == 9'h000
    |-> out_data == (cur == 8'h01 ? 8'h02 : impl ? 8'h01 : 8'h00)) else $error("bad revision");
  a_tail_zero: assert property (beat && cnt_reg >= (cur == 8'h00 ? 9'h00C : 9'h038)
    |-> out_data == 8'h00) else $error("reserved byte set");
  a_flags_byte: assert property (beat && impl && cur != 8'h00 && cnt_reg[2:0] == 3'h7
    && cnt_reg inside {[9'h00F:9'h037]} && !(cur == 8'h01 && cnt_reg == 9'h017)
    |-> out_data == 8'hC0) else $error("bad flags");
endmodule // stat_pages_props
bind stat_pages stat_pages_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
  .req_page(req_page), .req_ready(req_ready), .out_data(out_data), .out_last(out_last),
  .out_valid(out_valid), .out_ready(out_ready));
`default_nettype wire

// [bench/stat_pages_tb.sv]
// Self-checking bench for the statistics page formatter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module stat_pages_tb;
  import stat_pages_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  event_s events = '0;
  logic req_valid = 1'b0;
  logic [7:0] req_page = 8'h00;
  logic stall = 1'b0;
  logic clear = 1'b0;
  logic req_ready, out_last, out_valid, out_ready;
  logic [7:0] out_data;
  int failures = 0;
  int checks_done = 0;
  // 10 MHz clock
  always #50 clk_sys = !clk_sys;
  stat_pages DUT (.clk_sys(clk_sys), .rst_b(rst_b), .events(events), .req_valid(req_valid),
    .req_page(req_page), .req_ready(req_ready), .out_data(out_data), .out_last(out_last),
    .out_valid(out_valid), .out_ready(out_ready));
  stat_host host (.clk_sys(clk_sys), .rst_b(rst_b), .stall(stall), .clear(clear),
    .out_data(out_data), .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Request one page and gather it whole
  task read_page(input logic [7:0] pg);
    int i;
    req_valid = 1'b1;
    req_page = pg;
    clear = 1'b1;
    i = 0;
    while (!req_ready && i < 20)
    begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (!req_ready)
    begin
      failures++;
      $display("unexpected at %0t: request not taken", $time);
      wrap_up;
    end
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    clear = 1'b0;
    i = 0;
    while (!host.done && i < 2000)
    begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (!host.done)
    begin
      failures++;
      $display("unexpected at %0t: page timed out", $time);
      wrap_up;
    end
  endtask
  // Pulse one event for n cycles
  task bump(input event_s e, input int n);
    repeat (n) @(posedge clk_sys) #1 events = e;
    @(posedge clk_sys) #1 events = '0;
  endtask
  task chk_qw(input int ofs, input logic [63:0] v);
    for (int i = 0; i < 8; i++) `CHK(host.pg_buf[ofs + i], v[8 * i +: 8])
  endtask
  task chk_zero(input int from);
    for (int i = from; i < 512; i++) `CHK(host.pg_buf[i], 8'h00)
  endtask
  task t_index;
    read_page(8'h00);
    chk_qw(0, 64'h1);
    `CHK(host.pg_buf[8], 8'h03)
    `CHK(host.pg_buf[9], 8'h00)
    `CHK(host.pg_buf[10], 8'h01)
    `CHK(host.pg_buf[11], 8'h03)
    chk_zero(12);
    $display("index page done");
  endtask
  task t_general;
    stall = 1'b1;
    read_page(8'h01);
    stall = 1'b0;
    chk_qw(0, {40'h0, 8'h01, 16'h0002});
    chk_qw(8, {FLAGS_VALID, 24'h0, 32'd1});
    chk_qw(16, 64'd2);
    for (int k = 3; k < 7; k++) chk_qw(8 * k, {FLAGS_VALID, 8'h0, 48'(k)});
    chk_zero(56);
    $display("general page done");
  endtask
  task t_media;
    read_page(8'h03);
    chk_qw(0, {40'h0, 8'h03, 16'h0001});
    for (int k = 0; k < 6; k++) chk_qw(8 + 8 * k, {FLAGS_VALID, 24'h0, 32'(k + 7)});
    chk_zero(56);
    bump(event_s'(12'h020), 1);
    read_page(8'h03);
    chk_qw(8, {FLAGS_VALID, 24'h0, 32'd8});
    chk_qw(16, {FLAGS_VALID, 24'h0, 32'd8});
    $display("media page done");
  endtask
  task t_unimpl;
    logic [7:0] pgs [3] = '{8'h02, 8'h04, 8'hFF};
    foreach (pgs[j])
    begin
      read_page(pgs[j]);
      `CHK(host.n, 512)
      chk_zero(0);
      `CHK(host.supported, 1'b0)
    end
    $display("missing pages done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    for (int k = 0; k < 12; k++) bump(event_s'(12'h800 >> k), k + 1);
    t_index();
    t_general();
    t_media();
    t_unimpl();
    wrap_up();
  end
endmodule // stat_pages_tb
`default_nettype wire

// [core/stat_pages.sv]
// Statistics counters, log page formatter and output byte FIFO
`timescale 1ns/10ps
`default_nettype none

// Small word FIFO between the page formatter and the output register.
// Both sides use valid and ready; a word moves when both are high.
// Full and empty come from the fill level, so no pointer compare is needed.
module stat_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_reg; // Write pointer
  logic [AW-1:0] rd_reg; // Read pointer
  logic [AW:0] cnt_reg; // Fill level
  // Handshakes on each side
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // Full when the level reaches the depth, empty at zero
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  // Pointer and level update
  // Pointers wrap at the depth, so a depth that is not a power of two works
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Empty after reset
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end
endmodule // stat_fifo

// Log page formatter.
// Keeps one counter per statistic and takes a page request when idle.
// On taking it, the counters are copied so one page shows one instant.
// The 512-byte page then streams through the FIFO to a registered output.
// Unknown page numbers stream zeros, so the host always gets a full page.
// A new request is taken once the last byte has entered the FIFO.
// The sink may stall at any time; bytes are never dropped.
module stat_pages (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire stat_pages_pkg::event_s events, // Increment strobes, same clock
  input wire logic req_valid, // Page read request
  input wire logic [7:0] req_page, // Requested page number
  output logic req_ready, // Idle, request accepted
  output logic [7:0] out_data, // Page byte
  output logic out_last, // Final byte of page
  output logic out_valid, // Byte valid
  input wire logic out_ready // Sink accepts byte
);
  import stat_pages_pkg::*;

  // Sequencer states, one-hot
  // Idle waits for a request; send walks the 512 byte offsets
  // Any other code falls back to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } state_e;

  state_e state_reg; // Sequencer state
  logic [7:0] page_reg; // Page being sent
  logic [8:0] byte_reg; // Byte offset in page
  // Live counters, one per statistic
  logic [31:0] por_reg, poh_reg, spin_reg, fly_reg, load_reg, realloc_reg, recover_reg, fail_reg;
  logic [47:0] secwr_reg, cmdwr_reg, secrd_reg, cmdrd_reg;
  logic [31:0] snap32 [8]; // Snapshot, stable during a page
  logic [47:0] snap48 [4];
  logic [7:0] ob_data_reg; // Output stage
  logic ob_last_reg;
  logic ob_valid_reg;
  logic ready_reg; // Idle flag, drives req_ready

  // Statistic quadword: flags, reserved zero, value
  function automatic logic [63:0] stat_qw(input logic [47:0] v);
    stat_qw = {FLAGS_VALID, 8'h00, v};
  endfunction
  // Header quadword with zero upper bits
  function automatic logic [63:0] hdr_qw(input logic [7:0] pg, input logic [15:0] rev);
    hdr_qw = {40'h00_0000_0000, pg, rev};
  endfunction
  // Widen a 32-bit count into the 48-bit value field
  function automatic logic [47:0] z32(input logic [31:0] v);
    z32 = {16'h0000, v};
  endfunction
  // Add one strobe to a 32-bit count; wraps at full scale
  function automatic logic [31:0] inc32(input logic [31:0] c, input logic e);
    inc32 = c + {31'h0, e};
  endfunction
  // Add one strobe to a 48-bit count; wraps at full scale
  function automatic logic [47:0] inc48(input logic [47:0] c, input logic e);
    inc48 = c + {47'h0, e};
  endfunction

  // Counters: one per event, saturation not needed at these widths
  // Each strobe adds one in the cycle it is high; page reads never touch
  // the live counters, they only copy them into the snapshot
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // All counts start from zero
      por_reg <= CNT_RESET;
      poh_reg <= CNT_RESET;
      spin_reg <= CNT_RESET;
      fly_reg <= CNT_RESET;
      load_reg <= CNT_RESET;
      realloc_reg <= CNT_RESET;
      recover_reg <= CNT_RESET;
      fail_reg <= CNT_RESET;
      secwr_reg <= CNT48_RESET;
      cmdwr_reg <= CNT48_RESET;
      secrd_reg <= CNT48_RESET;
      cmdrd_reg <= CNT48_RESET;
    end
    else
    begin
      // General page statistics
      por_reg <= inc32(por_reg, events.por);
      poh_reg <= inc32(poh_reg, events.poh);
      // Rotating media statistics
      spin_reg <= inc32(spin_reg, events.spin_hr);
      fly_reg <= inc32(fly_reg, events.fly_hr);
      load_reg <= inc32(load_reg, events.load);
      realloc_reg <= inc32(realloc_reg, events.realloc);
      recover_reg <= inc32(recover_reg, events.recover);
      fail_reg <= inc32(fail_reg, events.start_fail);
      // 48-bit sector and command counts
      secwr_reg <= inc48(secwr_reg, events.sec_wr);
      cmdwr_reg <= inc48(cmdwr_reg, events.cmd_wr);
      secrd_reg <= inc48(secrd_reg, events.sec_rd);
      cmdrd_reg <= inc48(cmdrd_reg, events.cmd_rd);
    end
  end

  // Quadword select for the current byte
  // Bits 8:3 pick the quadword, bits 2:0 the byte lane within it
  wire [5:0] qw_idx = byte_reg[8:3];
  wire [2:0] lane = byte_reg[2:0];
  logic [63:0] qw_word;
  logic [7:0] idx_byte;
  logic [7:0] page_byte;
  // Index page bytes beyond the header
  // Count first, then page numbers in ascending order, then reserved zeros
  always_comb
  begin
    idx_byte = 8'h00;
    if (byte_reg == OFS_COUNT)
      idx_byte = INDEX_COUNT;
    else if (byte_reg == OFS_FIRST)
      idx_byte = PAGE_INDEX;
    else if (byte_reg == OFS_FIRST + 9'h001)
      idx_byte = PAGE_GENERAL;
    else if (byte_reg == OFS_FIRST + 9'h002)
      idx_byte = PAGE_MEDIA;
  end
  // Quadword content per page
  // Unused quadwords and unknown pages fall to zero
  always_comb
  begin
    qw_word = 64'h0;
    case (page_reg)
      // Index: only the header is a quadword, the list is bytewise
      PAGE_INDEX:
        if (qw_idx == 6'h00)
          qw_word = hdr_qw(PAGE_INDEX, REV_INDEX);
      // General: header, then six statistic quadwords
      PAGE_GENERAL:
        case (qw_idx)
          6'h00: qw_word = hdr_qw(PAGE_GENERAL, REV_GENERAL);
          6'h01: qw_word = stat_qw(z32(snap32[0]));
          6'h02: qw_word = {32'h0, snap32[1]}; // Power-on hours, no flags
          6'h03: qw_word = stat_qw(snap48[0]);
          6'h04: qw_word = stat_qw(snap48[1]);
          6'h05: qw_word = stat_qw(snap48[2]);
          6'h06: qw_word = stat_qw(snap48[3]);
          default: qw_word = 64'h0;
        endcase
      // Rotating media: header, then six statistic quadwords
      PAGE_MEDIA:
        case (qw_idx)
          6'h00: qw_word = hdr_qw(PAGE_MEDIA, REV_MEDIA);
          6'h01: qw_word = stat_qw(z32(snap32[2]));
          6'h02: qw_word = stat_qw(z32(snap32[3]));
          6'h03: qw_word = stat_qw(z32(snap32[4]));
          6'h04: qw_word = stat_qw(z32(snap32[5]));
          6'h05: qw_word = stat_qw(z32(snap32[6]));
          6'h06: qw_word = stat_qw(z32(snap32[7]));
          default: qw_word = 64'h0;
        endcase
      default: qw_word = 64'h0;
    endcase
  end
  // Little-endian byte pick; index body bytes come from the list
  wire idx_body = (page_reg == PAGE_INDEX) && (qw_idx != 6'h00);
  wire [7:0] lane_byte = qw_word[{lane, 3'b000} +: 8];
  assign page_byte = idx_body ? idx_byte : lane_byte;

  // Formatter to FIFO
  // A byte leaves only when the FIFO has room; the offset moves on each one
  wire fifo_in_ready;
  wire gen_valid = (state_reg == ST_SEND);
  wire gen_last = (byte_reg == 9'h1FF);
  wire gen_fire = gen_valid && fifo_in_ready;
  wire [BYTE_W-1:0] fifo_out;
  wire fifo_out_valid;
  wire ob_take = !ob_valid_reg || out_ready;
  byte_s gen_byte;
  assign gen_byte = '{data: page_byte, last: gen_last};
  assign req_ready = ready_reg; // Straight from its flop

  // Sequencer; snapshot counters on accept so a page is self-consistent
  // Idle: take a request and freeze the counters; send: one byte per FIFO slot
  // The offset wraps to zero after the last byte, ready for the next page
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      page_reg <= 8'h00;
      byte_reg <= 9'h000;
      for (int i = 0; i < 8; i++)
        snap32[i] <= CNT_RESET;
      for (int j = 0; j < 4; j++)
        snap48[j] <= CNT48_RESET;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (req_valid)
          begin
            state_reg <= ST_SEND;
            page_reg <= req_page;
            byte_reg <= 9'h000;
            // General page counts
            snap32[0] <= por_reg;
            snap32[1] <= poh_reg;
            // Rotating media counts
            snap32[2] <= spin_reg;
            snap32[3] <= fly_reg;
            snap32[4] <= load_reg;
            snap32[5] <= realloc_reg;
            snap32[6] <= recover_reg;
            snap32[7] <= fail_reg;
            // 48-bit sector and command counts
            snap48[0] <= secwr_reg;
            snap48[1] <= cmdwr_reg;
            snap48[2] <= secrd_reg;
            snap48[3] <= cmdrd_reg;
          end
        ST_SEND:
          if (gen_fire)
          begin
            byte_reg <= byte_reg + 9'h001;
            if (gen_last)
              state_reg <= ST_IDLE; // Full 512 bytes always sent
          end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Idle flag kept in its own flop so the port comes straight from a register
  // It follows the sequencer: low from the taken request to the last byte
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ready_reg <= 1'b1; // Idle out of reset
    else if (req_valid && ready_reg)
      ready_reg <= 1'b0; // Request taken, busy with a page
    else if (gen_fire && gen_last)
      ready_reg <= 1'b1; // Last byte handed to the FIFO
  end

  // Four-word buffer decouples the formatter from sink stalls
  stat_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(4)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_data(gen_byte),
    .in_valid(gen_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(ob_take)
  );

  // Registered output stage
  // Holds a byte until the sink takes it; loads whenever empty or draining,
  // so a steady ready gives one byte per cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ob_valid_reg <= 1'b0;
      ob_data_reg <= 8'h00;
      ob_last_reg <= 1'b0;
    end
    else if (ob_take)
    begin
      // Byte field sits above the last flag in the FIFO word
      ob_valid_reg <= fifo_out_valid;
      ob_data_reg <= fifo_out[8:1];
      ob_last_reg <= fifo_out[0];
    end
  end
  assign out_data = ob_data_reg;
  assign out_last = ob_last_reg;
  assign out_valid = ob_valid_reg;
endmodule // stat_pages

`default_nettype wire

// [core/stat_pages_pkg.sv]
// Constants, types and layout of the device statistics log pages
package stat_pages_pkg;
  localparam logic [7:0] PAGE_INDEX = 8'h00;
  localparam logic [7:0] PAGE_GENERAL = 8'h01;
  localparam logic [7:0] PAGE_MEDIA = 8'h03;
  localparam logic [15:0] REV_INDEX = 16'h0001;
  localparam logic [15:0] REV_GENERAL = 16'h0002;
  localparam logic [15:0] REV_MEDIA = 16'h0001;
  localparam logic [7:0] INDEX_COUNT = 8'h03;
  localparam logic [8:0] OFS_COUNT = 9'h008;
  localparam logic [8:0] OFS_FIRST = 9'h009;
  localparam logic [5:0] QW_LAST = 6'h3F;
  localparam logic [5:0] QW_STAT_LAST = 6'h06;
  localparam logic [7:0] FLAGS_VALID = 8'hC0;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [47:0] CNT48_RESET = 48'h0000_0000_0000;
  // Counter increment strobes, one bit per statistic
  typedef struct packed {
    logic por;
    logic poh;
    logic sec_wr;
    logic cmd_wr;
    logic sec_rd;
    logic cmd_rd;
    logic spin_hr;
    logic fly_hr;
    logic load;
    logic realloc;
    logic recover;
    logic start_fail;
  } event_s;
  // Byte out to the transport
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_s;
  localparam int BYTE_W = 9;
endpackage
